// *** rtl/sidc_indicator.v ***
// Overview of operation
// - With the extended enable clear, only the basic function set is reachable.
// - Function code is extended enable bit over four low bits of second register.
// - After the last pattern bit, hold it for step time times hold length.
// - Each pattern bit is shown for the programmed step time.
// - Default settings blink half a second on, half a second off.
// - Stretch select 00, 01, 10 give 32, 64 and 102 ms.
// - Stretch select 11 takes the six-bit custom stretch length instead.
// - Output disable bit set turns all indicator outputs off; clear drives them.
// - Stretch enable, reset to one, lengthens tx, rx, collision pulses.
// - With stretch enable clear, events pass at their natural length.
// - Second control register sits at 0x001C and resets to 0x210A.
`timescale 1ns/100ps
`include "sidc_map.vh"

module sidc_indicator #(
  parameter [21:0] STR0_CYC        = `SIDC_STR0_CYC,
  parameter [21:0] STR1_CYC        = `SIDC_STR1_CYC,
  parameter [21:0] STR2_CYC        = `SIDC_STR2_CYC,
  parameter [21:0] CUSTOM_UNIT_CYC = `SIDC_CUSTOM_UNIT_CYC,
  parameter [21:0] STEP_UNIT_CYC   = `SIDC_STEP_UNIT_CYC
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // Management register access
  input  wire [15:0] reg_addr,
  input  wire        reg_wr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata_r,
  output reg         reg_rvalid_r,
  // Line state, same clock domain
  input  wire        link_up,
  input  wire        full_duplex,
  input  wire [1:0]  link_speed,
  input  wire        tx_event,
  input  wire        rx_event,
  input  wire        col_event,
  // First indicator pin, high lights the lamp
  output reg         first_indicator_pin_r,
  output reg         first_indicator_oe_r
);

  reg  [15:0] ctrl1_r;
  reg  [15:0] ctrl2_r;
  reg  [15:0] ctrl3_r;
  reg  [5:0]  custom_stretch_length_r;

  wire        first_indicator_extended_set_enable = ctrl1_r[`SIDC_C1_EXT_BIT];
  wire [3:0]  pattern_hold_length = ctrl1_r[`SIDC_C1_HOLD_HI:`SIDC_C1_HOLD_LO];
  wire [1:0]  stretch_length_select = ctrl1_r[`SIDC_C1_SEL_HI:`SIDC_C1_SEL_LO];
  wire        indicator_output_disable = ctrl1_r[`SIDC_C1_DIS_BIT];
  wire        event_stretch_enable = ctrl1_r[`SIDC_C1_STR_BIT];
  wire [3:0]  first_indicator_function_low = ctrl2_r[`SIDC_C2_FUNC_HI:`SIDC_C2_FUNC_LO];
  wire [7:0]  blink_pattern_bits = ctrl3_r[`SIDC_C3_PAT_HI:`SIDC_C3_PAT_LO];
  wire [5:0]  pattern_step_time = ctrl3_r[`SIDC_C3_STEP_HI:`SIDC_C3_STEP_LO];

  // Register writes and registered reads
  always @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl1_r                 <= `SIDC_RST_CTRL1;
      ctrl2_r                 <= `SIDC_RST_CTRL2;
      ctrl3_r                 <= `SIDC_RST_CTRL3;
      custom_stretch_length_r <= `SIDC_RST_CUSTOM;
      reg_rdata_r             <= 16'h0000;
      reg_rvalid_r            <= 1'b0;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `SIDC_ADDR_CTRL1:  ctrl1_r <= reg_wdata & `SIDC_CTRL1_WMASK;
          `SIDC_ADDR_CTRL2:  ctrl2_r <= reg_wdata;
          `SIDC_ADDR_CTRL3:  ctrl3_r <= reg_wdata;
          `SIDC_ADDR_CUSTOM: custom_stretch_length_r <= reg_wdata[5:0];
          default: ;
        endcase
      end
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `SIDC_ADDR_CTRL1:  reg_rdata_r <= ctrl1_r;
          `SIDC_ADDR_CTRL2:  reg_rdata_r <= ctrl2_r;
          `SIDC_ADDR_CTRL3:  reg_rdata_r <= ctrl3_r;
          `SIDC_ADDR_CUSTOM: reg_rdata_r <= {10'h000, custom_stretch_length_r};
          default:           reg_rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  // Stretch length selection
  reg  [21:0] stretch_len;
  always @*  begin
    case (stretch_length_select)
      2'b00:   stretch_len = STR0_CYC;
      2'b01:   stretch_len = STR1_CYC;
      2'b10:   stretch_len = STR2_CYC;
      default: stretch_len = custom_stretch_length_r * CUSTOM_UNIT_CYC;
    endcase
  end

  // One stretcher per event: tx, rx, collision
  wire [2:0] ev_raw = {col_event, rx_event, tx_event};
  wire [2:0] ev_seen;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_str
      reg  [21:0] cnt_r;
      always @(posedge clk_sys) begin
        if (!nrst)
          cnt_r <= 22'h00_0000;
        else if (!event_stretch_enable)
          cnt_r <= 22'h00_0000;
        else if (ev_raw[gi])
          cnt_r <= stretch_len;
        else if (cnt_r != 22'h00_0000)
          cnt_r <= cnt_r - 22'h00_0001;
      end
      // Raw event always shows; counter only adds tail when enabled
      assign ev_seen[gi] = ev_raw[gi] | (cnt_r != 22'h00_0000);
    end
  endgenerate

  wire tx_seen  = ev_seen[0];
  wire rx_seen  = ev_seen[1];
  wire col_seen = ev_seen[2];
  wire activity = tx_seen | rx_seen;

  // Pattern engine: unit timer, step counter, bit index, hold phase
  reg  [21:0] unit_cnt_r;
  reg  [5:0]  step_cnt_r;
  reg  [2:0]  bit_idx_r;
  reg         holding_r;
  reg  [3:0]  hold_cnt_r;
  wire        unit_done = (unit_cnt_r == STEP_UNIT_CYC - 22'h00_0001);
  // A zero step time is treated as one unit so the engine never stalls
  wire [5:0]  step_last = (pattern_step_time == 6'h00) ? 6'h00 : pattern_step_time - 6'h01;
  wire        step_done = unit_done && (step_cnt_r >= step_last);

  always @(posedge clk_sys) begin
    if (!nrst) begin
      unit_cnt_r <= 22'h00_0000;
      step_cnt_r <= 6'h00;
      bit_idx_r  <= 3'h0;
      holding_r  <= 1'b0;
      hold_cnt_r <= 4'h0;
    end else begin
      unit_cnt_r <= unit_done ? 22'h00_0000 : unit_cnt_r + 22'h00_0001;
      if (unit_done)
        step_cnt_r <= step_done ? 6'h00 : step_cnt_r + 6'h01;
      if (step_done) begin
        if (holding_r) begin
          // Count up to the length, so a length cut to zero mid-hold ends it at the end of the current step
          if (hold_cnt_r + 4'h1 >= pattern_hold_length) begin
            holding_r  <= 1'b0;
            hold_cnt_r <= 4'h0;
            bit_idx_r  <= 3'h0;
          end else begin
            hold_cnt_r <= hold_cnt_r + 4'h1;
          end
        end else if (bit_idx_r == 3'h7) begin
          if (pattern_hold_length == 4'h0)
            bit_idx_r <= 3'h0;
          else
            holding_r <= 1'b1;
        end else begin
          bit_idx_r <= bit_idx_r + 3'h1;
        end
      end
    end
  end

  // Index stays at 7 while holding, so the last bit is what shows
  wire blink = blink_pattern_bits[bit_idx_r];

  // Function decode
  wire [4:0] func_code = {first_indicator_extended_set_enable,
                          first_indicator_function_low};
  wire       sp10   = link_up && (link_speed == `SIDC_SPD_10);
  wire       sp100  = link_up && (link_speed == `SIDC_SPD_100);
  wire       sp1000 = link_up && (link_speed == `SIDC_SPD_1000);
  reg        lamp;
  always @*  begin
    lamp = 1'b0;
    case (func_code)
      5'b00000: lamp = sp1000;
      5'b00001: lamp = sp100;
      5'b00010: lamp = sp10;
      5'b00011: lamp = sp1000 | (sp100 & blink);
      5'b00100: lamp = link_up;
      5'b00101: lamp = tx_seen;
      5'b00110: lamp = rx_seen;
      5'b00111: lamp = activity;
      5'b01000: lamp = link_up & full_duplex;
      5'b01001: lamp = col_seen;
      5'b01010: lamp = activity ? blink : link_up;
      5'b01011: lamp = rx_seen ? blink : link_up;
      5'b01100: lamp = col_seen ? blink : (link_up & full_duplex);
      5'b10000: lamp = sp100 | sp1000;
      5'b10011: lamp = sp100 & (activity ? blink : 1'b1);
      5'b10100: lamp = sp100 & (activity ? blink : 1'b1);
      5'b10110: lamp = (sp100 | sp1000) & (activity ? blink : 1'b1);
      5'b10111: lamp = sp10 | sp1000;
      5'b11000: lamp = (sp10 | sp1000) & (activity ? blink : 1'b1);
      5'b11001: lamp = activity & blink;
      5'b11010: lamp = tx_seen & blink;
      5'b11011: lamp = sp1000 | (sp10 & blink);
      5'b11111: lamp = sp10 | (sp100 & blink);
      default:  lamp = 1'b0;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      first_indicator_pin_r <= 1'b0;
      first_indicator_oe_r  <= 1'b0;
    end else begin
      first_indicator_oe_r  <= ~indicator_output_disable;
      first_indicator_pin_r <= lamp & ~indicator_output_disable;
    end
  end

endmodule

// *** rtl/sidc_map.vh ***
`ifndef SIDC_MAP_VH
`define SIDC_MAP_VH

// Management register addresses
`define SIDC_ADDR_CTRL1       16'h001B
`define SIDC_ADDR_CTRL2       16'h001C
`define SIDC_ADDR_CTRL3       16'h001D
`define SIDC_ADDR_CUSTOM      16'hBC00

// Reset values
`define SIDC_RST_CTRL1        16'h0001
`define SIDC_RST_CTRL2        16'h210A
`define SIDC_RST_CTRL3        16'h1855
`define SIDC_RST_CUSTOM       6'h00

// Writable bits of the first control register; [9:8] read as zero
`define SIDC_CTRL1_WMASK      16'hFCFF

// First control register fields
`define SIDC_C1_EXT_BIT       10
`define SIDC_C1_HOLD_HI       7
`define SIDC_C1_HOLD_LO       4
`define SIDC_C1_SEL_HI        3
`define SIDC_C1_SEL_LO        2
`define SIDC_C1_DIS_BIT       1
`define SIDC_C1_STR_BIT       0

// Second and third control register fields
`define SIDC_C2_FUNC_HI       3
`define SIDC_C2_FUNC_LO       0
`define SIDC_C3_PAT_HI        7
`define SIDC_C3_PAT_LO        0
`define SIDC_C3_STEP_HI       13
`define SIDC_C3_STEP_LO       8

// Timing, times in microseconds
`define SIDC_CLK_MHZ          10
`define SIDC_STR0_US          32000
`define SIDC_STR1_US          64000
`define SIDC_STR2_US          102000
`define SIDC_CUSTOM_UNIT_US   2000
`define SIDC_STEP_UNIT_US     20833
`define SIDC_STR0_CYC         (`SIDC_STR0_US * `SIDC_CLK_MHZ)
`define SIDC_STR1_CYC         (`SIDC_STR1_US * `SIDC_CLK_MHZ)
`define SIDC_STR2_CYC         (`SIDC_STR2_US * `SIDC_CLK_MHZ)
`define SIDC_CUSTOM_UNIT_CYC  (`SIDC_CUSTOM_UNIT_US * `SIDC_CLK_MHZ)
`define SIDC_STEP_UNIT_CYC    (`SIDC_STEP_UNIT_US * `SIDC_CLK_MHZ)

// Speed codes
`define SIDC_SPD_10           2'b00
`define SIDC_SPD_100          2'b01
`define SIDC_SPD_1000         2'b10

`endif

// *** bench/sidc_chk_sva.sv ***
`timescale 1ns/100ps
module sidc_chk (
  // Clock and reset
  input wire        clk_sys,
  input wire        nrst,
  // Register port
  input wire [15:0] reg_addr,
  input wire        reg_wr,
  input wire [15:0] reg_wdata,
  input wire        reg_rd,
  input wire [15:0] reg_rdata_r,
  input wire        reg_rvalid_r,
  // Indicator pin
  input wire        first_indicator_pin_r,
  input wire        first_indicator_oe_r
);
  reg  dis_r;
  wire a1b = reg_addr == 16'h001B;
  wire a1c = reg_addr == 16'h001C;
  wire map = a1b || a1c || reg_addr == 16'h001D || reg_addr == 16'hBC00;
  // Shadow of the output disable bit
  always @(posedge clk_sys) begin
    if (!nrst)
      dis_r <= 1'b0;
    else if (reg_wr && a1b)
      dis_r <= reg_wdata[1];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_wr2; reg_wr && a1c; endsequence
  sequence s_rd2; reg_rd && !reg_wr && a1c; endsequence
  a_read_valid: assert property (reg_rd |=> reg_rvalid_r)
    else $error("read valid missing");
  a_valid_cause: assert property (reg_rvalid_r |-> $past(reg_rd))
    else $error("read valid without read");
  a_unmapped_zero: assert property (reg_rd && !map |=> reg_rdata_r == 16'h0000)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (reg_rd && a1b |=> reg_rdata_r[9:8] == 2'b00)
    else $error("reserved bits not zero");
  a_custom_upper: assert property (reg_rd && reg_addr == 16'hBC00 |=> reg_rdata_r[15:6] == 0)
    else $error("custom length upper bits set");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_r))
    else $error("read data changed without read");
  a_ctrl2_rw: assert property (s_wr2 ##1 s_rd2 |=> reg_rdata_r == $past(reg_wdata, 2))
    else $error("second control readback wrong");
  a_dis_off: assert property (dis_r |=> !first_indicator_oe_r && !first_indicator_pin_r)
    else $error("pin active while disabled");
  a_en_drive: assert property (nrst && !dis_r |=> first_indicator_oe_r)
    else $error("pin not driven while enabled");
endmodule
bind sidc_indicator sidc_chk u_chk (
  .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
  .reg_rvalid_r(reg_rvalid_r), .first_indicator_pin_r(first_indicator_pin_r),
  .first_indicator_oe_r(first_indicator_oe_r)
);

// *** bench/sidc_lamp.sv ***
`timescale 1ns/100ps
module sidc_lamp (
  // Pin drive
  input  wire pin,
  input  wire oe,
  // Lamp state
  output wire lit
);
  // Undriven pin is pulled low, so the lamp goes dark
  assign lit = oe & pin;
endmodule

// *** bench/sidc_indicator_bench.sv ***
`timescale 1ns/100ps
module sidc_indicator_bench;
  reg          clk_sys = 1'b0;
  reg          nrst = 1'b0;
  reg  [15:0]  reg_addr = 16'h0000;
  reg          reg_wr = 1'b0;
  reg  [15:0]  reg_wdata = 16'h0000;
  reg          reg_rd = 1'b0;
  reg          link_up = 1'b0;
  reg          full_duplex = 1'b0;
  reg  [1:0]   link_speed = 2'b00;
  reg  [2:0]   ev = 3'b000;
  reg  [31:0]  lf = 32'd83201;
  wire [15:0]  rdata;
  wire         rvalid, pin, oe, lit;
  integer      n_fail = 0, tests_run = 0, cyc = 0, n, i, s;
  integer      len[4] = '{20, 40, 60, 10};
  logic [15:0] q[$];
  sidc_indicator #(.STR0_CYC(20), .STR1_CYC(40), .STR2_CYC(60), .CUSTOM_UNIT_CYC(2),
    .STEP_UNIT_CYC(4)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_r(rdata),
    .reg_rvalid_r(rvalid), .link_up(link_up), .full_duplex(full_duplex),
    .link_speed(link_speed), .tx_event(ev[0]), .rx_event(ev[1]), .col_event(ev[2]),
    .first_indicator_pin_r(pin), .first_indicator_oe_r(oe));
  sidc_lamp u_lamp (.pin(pin), .oe(oe), .lit(lit));
  initial forever #50 clk_sys = ~clk_sys;
  function [15:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    rnd = lf[15:0];
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    tests_run++;
    if (e !== g) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Write, then read the same place back on the next cycle when r is set
  task op(input [15:0] a, input [15:0] d, input r, input [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= r;
    if (r)
      q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  // Read only, no write before it
  task rd(input [15:0] a, input [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task lamp(input [15:0] e);
    repeat (4) @(posedge clk_sys);
    chk("lit", e, {15'h0000, lit});
  endtask
  // Event burst of k cycles; counts cycles the lamp is lit
  task pulse(input [2:0] e, input integer k, input integer x);
    n = 0;
    for (i = 0; i < 150; i++) begin
      @(posedge clk_sys);
      ev <= (i < k) ? e : 3'b000;
      if (lit === 1'b1)
        n++;
    end
    chk("lit_len", x, n);
  endtask
  // Lit cycles over one pattern period w, after w cycles to settle
  task win(input integer w, input integer x);
    repeat (w) @(posedge clk_sys);
    n = 0;
    for (i = 0; i < w; i++) begin
      @(posedge clk_sys);
      if (lit === 1'b1)
        n++;
    end
    chk("lit_cnt", x, n);
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rvalid === 1'b1)
      chk("rdata", q.pop_front(), rdata);
    if (cyc == 20000) begin
      n_fail++;
      give_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(16'h001B, 16'h0001);
    rd(16'h001C, 16'h210A);
    rd(16'h001D, 16'h1855);
    rd(16'hBC00, 16'h0000);
    rd(16'h0000, 16'h0000);
    $display("reset values done");
    n = rnd();
    op(16'h001C, n, 1, n);
    n = rnd();
    op(16'h001B, n, 1, n & 16'hFCFF);
    n = rnd();
    op(16'hBC00, n, 1, n & 16'h003F);
    op(16'h001B, 16'h0001, 0, 0);
    $display("register access done");
    link_up <= 1'b1;
    op(16'h001C, 16'h2102, 0, 0);
    lamp(1);
    op(16'h001B, 16'h0401, 0, 0);
    lamp(0);
    op(16'h001B, 16'h0001, 0, 0);
    op(16'h001C, 16'h2108, 0, 0);
    full_duplex <= 1'b1;
    lamp(1);
    full_duplex <= 1'b0;
    lamp(0);
    $display("function select done");
    op(16'h001C, 16'h2107, 0, 0);
    op(16'hBC00, 16'h0005, 0, 0);
    for (s = 0; s < 4; s++) begin
      op(16'h001B, 16'h0001 | (s << 2), 0, 0);
      pulse(3'b001, 1, 1 + len[s]);
    end
    op(16'h001B, 16'h0000, 0, 0);
    pulse(3'b010, 3, 3);
    op(16'h001C, 16'h2109, 0, 0);
    op(16'h001B, 16'h0001, 0, 0);
    pulse(3'b100, 2, 22);
    $display("stretch done");
    op(16'h001C, 16'h2104, 0, 0);
    op(16'h001B, 16'h0003, 0, 0);
    lamp(0);
    chk("oe", 0, {15'h0000, oe});
    pulse(3'b001, 2, 0);
    op(16'h001B, 16'h0001, 0, 0);
    lamp(1);
    $display("output disable done");
    // Function 00011 at 100M shows the blink pattern itself
    op(16'h001C, 16'h2103, 0, 0);
    link_speed <= 2'b01;
    win(768, 384);
    op(16'h001D, 16'h0281, 0, 0);
    op(16'h001B, 16'h0031, 0, 0);
    win(88, 40);
    op(16'h001B, 16'h0001, 0, 0);
    win(64, 16);
    $display("pattern done");
    give_verdict;
  end
endmodule
